// File: rtl/pfh_packet_handler.sv
// Packet handler: FIFO pointers, transmit framer and receive deframer
`timescale 1ns/1ps
// Operation
// - Fixed format: length setting is packet length; variable: largest accepted length
// - Receiver compares first payload byte with node address while filtering is on
// - Format setting picks fixed or variable length for transmit and receive
// - Transmitter sends one preamble byte more than the preamble size setting
// - Address filter setting enables filtering and picks accepted addresses
// - CRC failure with auto-clear enabled empties the FIFO
// - In standby the access setting allows host writes (0) or reads (1)
// - Start condition 1 starts the first packet after entering transmit once FIFO is not empty
// - After entering transmit the device waits its ready time then sends
// - Receiver ignores sync until its start-up delay has passed
// - Start condition 1: FIFO cleared after packet, surplus bytes lost
// - Start condition 0: surplus bytes stay for further packets
// - New reception starts only when the FIFO is empty
// - Payload ready rises with final byte, holds until FIFO is read empty
// - Address match and CRC ok hold until payload fully read
// - CRC status is valid when CRC ok and payload ready fire
// - Read in receive mode: CRC status clears when FIFO empties
// - Read elsewhere: CRC status holds until new sync in receive
// - Mode codes: 000 sleep, 001 standby, 010 synth, 011 receive, 100 transmit
// - Data mode with upper bit set selects packet handling
module pfh_packet_handler (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire pfh_pkg::pfh_cfg_t cfg_i,
  input wire logic host_wr_i,
  input wire logic [7:0] host_wdata_i,
  input wire logic host_rd_i,
  output logic [7:0] host_rdata_o,
  input wire logic bit_tick_i,
  output logic tx_bit_o,
  output logic tx_active_o,
  input wire logic rx_bit_i,
  input wire logic rx_bit_valid_i,
  input wire logic rx_sync_i,
  output pfh_pkg::pfh_stat_t stat_o
);
  typedef struct packed {
    pfh_pkg::pfh_tx_st_t tst;
    pfh_pkg::pfh_rx_st_t rst;
    logic [11:0] tmr;
    logic [pfh_pkg::PTR_W-1:0] wptr;
    logic [pfh_pkg::PTR_W-1:0] rptr;
    logic [6:0] count;
    logic [7:0] sh;
    logic [2:0] bitn;
    logic half;
    logic [1:0] pre_cnt;
    logic [7:0] remain;
    logic [8:0] lfsr;
    logic [15:0] crc;
    logic [7:0] crc_hi;
    logic rlen;
    logic radr;
    logic tx_bit;
    logic tx_active;
    pfh_pkg::pfh_stat_t stat;
  } pfh_core_st_t;

  pfh_core_st_t s;
  pfh_core_st_t next_s;
  logic [7:0] rdata;
  logic pkt;
  logic in_tx;
  logic in_rx;
  logic [7:0] wmask;
  logic host_push;
  logic host_pop;
  logic tx_pop;
  logic rx_push;
  logic fifo_clr;
  logic rx_fin;
  logic tx_step;
  logic tx_man;
  logic byte_end;
  logic load_body;
  logic tx_end;
  logic tx_ready_pkt;
  logic [8:0] tx_need;
  logic rx_take;
  logic rbyte_done;
  logic [7:0] rbyte;
  logic adr_ok;
  logic empty_by_read;
  logic [7:0] wdata;

  always_comb begin
    next_s = s;
    pkt = cfg_i.data_mode[pfh_pkg::DATA_MODE_PKT_BIT];
    in_tx = pkt && (cfg_i.chip_mode == pfh_pkg::MODE_TX);
    in_rx = pkt && (cfg_i.chip_mode == pfh_pkg::MODE_RX);
    wmask = cfg_i.whitening_on ? s.lfsr[7:0] : 8'h00;
    tx_pop = 1'b0;
    rx_push = 1'b0;
    fifo_clr = 1'b0;
    rx_fin = 1'b0;
    load_body = 1'b0;
    tx_end = 1'b0;
    rbyte_done = 1'b0;
    // Host access direction follows the mode; standby uses the access setting
    host_push = host_wr_i && (s.count != pfh_pkg::FIFO_FULL_LVL) && ((cfg_i.chip_mode == pfh_pkg::MODE_TX)
      || (cfg_i.chip_mode == pfh_pkg::MODE_STBY && !cfg_i.fifo_stby_access));
    host_pop = host_rd_i && (s.count != 7'h0) && ((cfg_i.chip_mode == pfh_pkg::MODE_RX)
      || (cfg_i.chip_mode == pfh_pkg::MODE_STBY && cfg_i.fifo_stby_access));

    // Transmit: start condition
    tx_need = cfg_i.pkt_format ? ({1'b0, rdata} + 9'h001) : {1'b0, cfg_i.payload_length};
    if (cfg_i.tx_start_cond) begin
      tx_ready_pkt = (s.count != 7'h0);
    end else begin
      // A queued packet longer than the FIFO can never start in this mode
      tx_ready_pkt = (s.count != 7'h0) && ({2'b00, s.count} >= tx_need);
    end

    // Transmit: bit engine, Manchester covers everything after the preamble
    tx_step = bit_tick_i && (s.tst == pfh_pkg::T_PRE || s.tst == pfh_pkg::T_BODY
      || s.tst == pfh_pkg::T_CRC_HI || s.tst == pfh_pkg::T_CRC_LO);
    tx_man = cfg_i.manchester_on && (s.tst != pfh_pkg::T_PRE);
    byte_end = (s.bitn == 3'h7) && (!tx_man || s.half);
    if (tx_step) begin
      next_s.tx_bit = s.sh[7] ^ (tx_man & s.half);
      if (tx_man && !s.half) begin
        next_s.half = 1'b1;
      end else begin
        next_s.half = 1'b0;
        next_s.sh = {s.sh[6:0], 1'b0};
        next_s.bitn = s.bitn + 3'h1;
      end
    end

    case (s.tst)
      pfh_pkg::T_IDLE: begin
        if (in_tx) begin
          next_s.tst = pfh_pkg::T_WARM;
          next_s.tmr = pfh_pkg::TX_READY_CYC;
        end
      end
      pfh_pkg::T_WARM, pfh_pkg::T_DONE: begin
        if (s.tmr != 12'h000) begin
          next_s.tmr = s.tmr - 12'h001;
        end else if (tx_ready_pkt && (s.tst == pfh_pkg::T_WARM || !cfg_i.tx_start_cond)) begin
          next_s.tst = pfh_pkg::T_PRE;
          next_s.sh = pfh_pkg::PREAMBLE_BYTE;
          next_s.pre_cnt = cfg_i.preamble_size;
          next_s.bitn = 3'h0;
          next_s.half = 1'b0;
          next_s.lfsr = pfh_pkg::PN9_SEED;
          next_s.crc = pfh_pkg::CRC_SEED;
          next_s.tx_active = 1'b1;
        end
      end
      pfh_pkg::T_PRE: begin
        if (tx_step && byte_end) begin
          if (s.pre_cnt == 2'h0) begin
            load_body = 1'b1;
          end else begin
            next_s.pre_cnt = s.pre_cnt - 2'h1;
            next_s.sh = pfh_pkg::PREAMBLE_BYTE;
          end
        end
      end
      pfh_pkg::T_BODY: begin
        if (tx_step && byte_end) begin
          if (s.remain != 8'h00) begin
            load_body = 1'b1;
          end else if (cfg_i.crc_on) begin
            next_s.tst = pfh_pkg::T_CRC_HI;
            next_s.sh = s.crc[15:8] ^ wmask;
            next_s.lfsr = pfh_pkg::pn9_adv8(s.lfsr);
          end else begin
            tx_end = 1'b1;
          end
        end
      end
      pfh_pkg::T_CRC_HI: begin
        if (tx_step && byte_end) begin
          next_s.tst = pfh_pkg::T_CRC_LO;
          next_s.sh = s.crc[7:0] ^ wmask;
          next_s.lfsr = pfh_pkg::pn9_adv8(s.lfsr);
        end
      end
      pfh_pkg::T_CRC_LO: begin
        if (tx_step && byte_end) begin
          tx_end = 1'b1;
        end
      end
      default: begin
        next_s.tst = pfh_pkg::T_IDLE;
      end
    endcase

    if (load_body) begin
      if (s.count == 7'h0) begin
        // Underrun ends the packet early rather than sending stale bytes
        tx_end = 1'b1;
      end else begin
        tx_pop = 1'b1;
        next_s.tst = pfh_pkg::T_BODY;
        next_s.sh = rdata ^ wmask;
        next_s.lfsr = pfh_pkg::pn9_adv8(s.lfsr);
        next_s.crc = pfh_pkg::crc_upd(s.crc, rdata);
        if (s.tst == pfh_pkg::T_PRE) begin
          next_s.remain = cfg_i.pkt_format ? rdata : (cfg_i.payload_length - 8'h01);
        end else begin
          next_s.remain = s.remain - 8'h01;
        end
      end
    end

    if (tx_end) begin
      next_s.tst = pfh_pkg::T_DONE;
      next_s.tx_active = 1'b0;
      next_s.stat.tx_done = 1'b1;
      fifo_clr = cfg_i.tx_start_cond;
    end
    if (!in_tx) begin
      // Leaving transmit mid-byte must neither consume nor clear queued bytes
      tx_pop = 1'b0;
      fifo_clr = 1'b0;
      next_s.tst = pfh_pkg::T_IDLE;
      next_s.tx_active = 1'b0;
      next_s.tx_bit = 1'b0;
      next_s.stat.tx_done = 1'b0;
    end

    // Receive: chip pairing and byte assembly, first chip of a pair carries the bit
    rx_take = rx_bit_valid_i && (s.rst == pfh_pkg::R_BODY || s.rst == pfh_pkg::R_CRC)
      && (!cfg_i.manchester_on || !s.half);
    if (rx_bit_valid_i && (s.rst == pfh_pkg::R_BODY || s.rst == pfh_pkg::R_CRC) && cfg_i.manchester_on) begin
      next_s.half = ~s.half;
    end
    rbyte = {s.sh[6:0], rx_bit_i} ^ wmask;
    adr_ok = (rbyte == cfg_i.node_adrs)
      || (cfg_i.adrs_filt != pfh_pkg::FILT_NODE && rbyte == pfh_pkg::BCAST_ZERO)
      || (cfg_i.adrs_filt == pfh_pkg::FILT_NODE_BC && rbyte == pfh_pkg::BCAST_ONES);
    if (rx_take) begin
      next_s.sh = {s.sh[6:0], rx_bit_i};
      next_s.bitn = s.bitn + 3'h1;
      rbyte_done = (s.bitn == 3'h7);
    end

    case (s.rst)
      pfh_pkg::R_IDLE: begin
        if (in_rx) begin
          next_s.rst = pfh_pkg::R_WARM;
          next_s.tmr = pfh_pkg::RX_READY_CYC;
        end
      end
      pfh_pkg::R_WARM: begin
        if (s.tmr != 12'h000) begin
          next_s.tmr = s.tmr - 12'h001;
        end else begin
          next_s.rst = pfh_pkg::R_HUNT;
        end
      end
      pfh_pkg::R_HUNT: begin
        if (rx_sync_i && s.count == 7'h0) begin
          next_s.rst = pfh_pkg::R_BODY;
          next_s.stat.crc_status = 1'b0;
          next_s.lfsr = pfh_pkg::PN9_SEED;
          next_s.crc = pfh_pkg::CRC_SEED;
          next_s.bitn = 3'h0;
          next_s.half = 1'b0;
          next_s.rlen = cfg_i.pkt_format;
          next_s.radr = (cfg_i.adrs_filt != pfh_pkg::FILT_OFF);
          next_s.remain = cfg_i.payload_length;
        end
      end
      pfh_pkg::R_BODY: begin
        if (rbyte_done) begin
          next_s.lfsr = pfh_pkg::pn9_adv8(s.lfsr);
          next_s.crc = pfh_pkg::crc_upd(s.crc, rbyte);
          if (s.rlen) begin
            next_s.rlen = 1'b0;
            next_s.remain = rbyte;
            if (rbyte == 8'h00 || rbyte > cfg_i.payload_length) begin
              fifo_clr = 1'b1;
            end
          end else if (s.radr && !adr_ok) begin
            fifo_clr = 1'b1;
          end else begin
            rx_push = (s.count != pfh_pkg::FIFO_FULL_LVL);
            next_s.radr = 1'b0;
            next_s.stat.adrs_match = s.stat.adrs_match | s.radr;
            next_s.remain = s.remain - 8'h01;
            if (s.remain == 8'h01 && cfg_i.crc_on) begin
              next_s.rst = pfh_pkg::R_CRC;
              next_s.remain = pfh_pkg::RX_CRC_PENDING;
            end else if (s.remain == 8'h01) begin
              rx_fin = 1'b1;
              next_s.rst = pfh_pkg::R_HUNT;
              next_s.stat.payload_ready = 1'b1;
            end
          end
          if (fifo_clr) begin
            next_s.rst = pfh_pkg::R_HUNT;
            next_s.stat.adrs_match = 1'b0;
          end
        end
      end
      pfh_pkg::R_CRC: begin
        if (rbyte_done) begin
          next_s.lfsr = pfh_pkg::pn9_adv8(s.lfsr);
          next_s.crc_hi = rbyte;
          next_s.remain = s.remain - 8'h01;
          if (s.remain != pfh_pkg::RX_CRC_PENDING) begin
            rx_fin = 1'b1;
            next_s.rst = pfh_pkg::R_HUNT;
            next_s.stat.crc_status = ({s.crc_hi, rbyte} == s.crc);
            next_s.stat.crc_ok = ({s.crc_hi, rbyte} == s.crc);
            if ({s.crc_hi, rbyte} != s.crc && cfg_i.crc_autoclr) begin
              fifo_clr = 1'b1;
              next_s.stat.adrs_match = 1'b0;
            end else begin
              next_s.stat.payload_ready = 1'b1;
            end
          end
        end
      end
      default: begin
        next_s.rst = pfh_pkg::R_IDLE;
      end
    endcase
    if (!in_rx) begin
      next_s.rst = pfh_pkg::R_IDLE;
    end

    // FIFO pointers; a clear wins over any push or pop in the same cycle
    empty_by_read = host_pop && !rx_push && !host_push && (s.count == 7'h1) && !fifo_clr;
    if (fifo_clr) begin
      next_s.rptr = s.wptr;
      next_s.count = 7'h0;
    end else begin
      if (host_push || rx_push) begin
        next_s.wptr = s.wptr + {{(pfh_pkg::PTR_W-1){1'b0}}, 1'b1};
      end
      if (host_pop || tx_pop) begin
        next_s.rptr = s.rptr + {{(pfh_pkg::PTR_W-1){1'b0}}, 1'b1};
      end
      next_s.count = s.count + {6'h00, host_push | rx_push} - {6'h00, host_pop | tx_pop};
    end
    // A completion landing in the emptying cycle keeps its flags
    if (empty_by_read && !rx_fin) begin
      next_s.stat.payload_ready = 1'b0;
      next_s.stat.crc_ok = 1'b0;
      next_s.stat.adrs_match = 1'b0;
      if (cfg_i.chip_mode == pfh_pkg::MODE_RX) begin
        next_s.stat.crc_status = 1'b0;
      end
    end
    next_s.stat.fifo_not_empty = (next_s.count != 7'h0);
    next_s.stat.fifo_full = (next_s.count == pfh_pkg::FIFO_FULL_LVL);
    wdata = rx_push ? rbyte : host_wdata_i;
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  pfh_fifo_mem u_mem (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .wr_i(host_push | rx_push),
    .waddr_i(s.wptr),
    .wdata_i(wdata),
    .raddr_i(next_s.rptr),
    .rdata_o(rdata)
  );

  assign host_rdata_o = rdata;
  assign tx_bit_o = s.tx_bit;
  assign tx_active_o = s.tx_active;
  assign stat_o = s.stat;

  a_rx_empty_start: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (s.rst == pfh_pkg::R_HUNT && rx_sync_i && s.count != 7'h0) |=> (s.rst != pfh_pkg::R_BODY))
    else $error("reception started with data left in the FIFO");
  a_tx_warm_wait: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (s.tst == pfh_pkg::T_WARM && s.tmr != 12'h000) |=> (s.tst != pfh_pkg::T_PRE))
    else $error("transmit began before ready time");
  a_rx_warm_wait: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (s.rst == pfh_pkg::R_WARM && s.tmr != 12'h000) |=> (s.rst != pfh_pkg::R_HUNT && s.rst != pfh_pkg::R_BODY))
    else $error("receiver armed before start-up delay");
  a_tx_start_now: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (s.tst == pfh_pkg::T_WARM && s.tmr == 12'h000 && in_tx && cfg_i.tx_start_cond && s.count != 7'h0)
    |=> (s.tst == pfh_pkg::T_PRE && s.tx_active))
    else $error("transmit did not start on non-empty FIFO");
  a_pr_hold_read: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    s.stat.payload_ready |=> (s.stat.payload_ready || $past(s.count) == 7'h1 || $past(fifo_clr)))
    else $error("payload ready dropped before FIFO emptied");
  a_crc_ok_hold: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (s.stat.crc_ok && !host_pop && !fifo_clr) |=> s.stat.crc_ok)
    else $error("crc ok dropped without a read");
  a_crc_stat_keep: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (s.stat.crc_status && cfg_i.chip_mode != pfh_pkg::MODE_RX) |=> s.stat.crc_status)
    else $error("crc status cleared outside receive");
  a_crc_stat_rxclr: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (in_rx && empty_by_read && !rx_fin) |=> (!s.stat.crc_status && !s.stat.payload_ready))
    else $error("crc status kept after payload read in receive");
  a_tx_surplus_clr: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    ($rose(s.stat.tx_done) && $past(cfg_i.tx_start_cond)) |-> (s.count == 7'h0))
    else $error("surplus bytes left after packet");
  a_stby_no_read: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (cfg_i.chip_mode == pfh_pkg::MODE_STBY && !cfg_i.fifo_stby_access && !host_wr_i)
    |=> (s.count == $past(s.count)))
    else $error("FIFO drained in standby write access");
endmodule : pfh_packet_handler

// File: rtl/pfh_pkg.sv
// Constants, carriers and helpers shared by the packet FIFO handler
package pfh_pkg;
  localparam int CLK_PERIOD_NS = 25;
  localparam int TX_READY_US = 60;
  localparam int RX_READY_US = 100;
  localparam logic [11:0] TX_READY_CYC = 12'((TX_READY_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [11:0] RX_READY_CYC = 12'((RX_READY_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam int FIFO_DEPTH = 64;
  localparam int PTR_W = 6;
  localparam logic [6:0] FIFO_FULL_LVL = 7'h40;
  localparam logic [2:0] MODE_SLEEP = 3'h0;
  localparam logic [2:0] MODE_STBY = 3'h1;
  localparam logic [2:0] MODE_FS = 3'h2;
  localparam logic [2:0] MODE_RX = 3'h3;
  localparam logic [2:0] MODE_TX = 3'h4;
  localparam int DATA_MODE_PKT_BIT = 1;
  localparam logic [1:0] FILT_OFF = 2'h0;
  localparam logic [1:0] FILT_NODE = 2'h1;
  localparam logic [1:0] FILT_NODE_BC0 = 2'h2;
  localparam logic [1:0] FILT_NODE_BC = 2'h3;
  localparam logic [7:0] BCAST_ZERO = 8'h00;
  localparam logic [7:0] BCAST_ONES = 8'hFF;
  localparam logic [7:0] PREAMBLE_BYTE = 8'hAA;
  localparam logic [8:0] PN9_SEED = 9'h1FF;
  localparam logic [15:0] CRC_SEED = 16'hFFFF;
  localparam logic [15:0] CRC_POLY = 16'h1021;
  localparam logic [7:0] RX_CRC_PENDING = 8'h02;

  typedef enum logic [2:0] {T_IDLE, T_WARM, T_PRE, T_BODY, T_CRC_HI, T_CRC_LO, T_DONE} pfh_tx_st_t;
  typedef enum logic [2:0] {R_IDLE, R_WARM, R_HUNT, R_BODY, R_CRC} pfh_rx_st_t;

  typedef struct packed {
    logic [2:0] chip_mode;
    logic [1:0] data_mode;
    logic pkt_format;
    logic [7:0] payload_length;
    logic [7:0] node_adrs;
    logic [1:0] preamble_size;
    logic manchester_on;
    logic whitening_on;
    logic crc_on;
    logic [1:0] adrs_filt;
    logic crc_autoclr;
    logic fifo_stby_access;
    logic tx_start_cond;
  } pfh_cfg_t;

  typedef struct packed {
    logic payload_ready;
    logic crc_ok;
    logic adrs_match;
    logic crc_status;
    logic tx_done;
    logic fifo_not_empty;
    logic fifo_full;
  } pfh_stat_t;

  function automatic logic [8:0] pn9_adv8(input logic [8:0] l);
    logic [8:0] v;
    v = l;
    for (int i = 0; i < 8; i++) begin
      v = {v[0] ^ v[5], v[8:1]};
    end
    return v;
  endfunction : pn9_adv8

  function automatic logic [15:0] crc_upd(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] v;
    v = c;
    for (int i = 7; i >= 0; i--) begin
      v = (v[15] ^ b[i]) ? ({v[14:0], 1'b0} ^ CRC_POLY) : {v[14:0], 1'b0};
    end
    return v;
  endfunction : crc_upd
endpackage : pfh_pkg

// File: rtl/pfh_fifo_mem.sv
// Byte storage of the packet FIFO with a registered read port
`timescale 1ns/1ps
module pfh_fifo_mem (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic wr_i,
  input wire logic [pfh_pkg::PTR_W-1:0] waddr_i,
  input wire logic [7:0] wdata_i,
  input wire logic [pfh_pkg::PTR_W-1:0] raddr_i,
  output logic [7:0] rdata_o
);
  typedef struct packed {
    logic [pfh_pkg::FIFO_DEPTH-1:0][7:0] mem;
    logic [7:0] rdata;
  } pfh_mem_st_t;

  pfh_mem_st_t s;
  pfh_mem_st_t next_s;

  always_comb begin
    next_s = s;
    if (wr_i) begin
      next_s.mem[waddr_i] = wdata_i;
    end
    // Reading the updated array gives write-through, so a byte written to an empty FIFO shows next cycle
    next_s.rdata = next_s.mem[raddr_i];
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign rdata_o = s.rdata;
endmodule : pfh_fifo_mem

// File: dv/pfh_modem_model.sv
// Modem stand-in: chip ticks, transmit chip capture, receive chips and sync
`timescale 1ns/1ps
module pfh_modem_model (
  input wire logic sys_clk_i,
  input wire logic tx_bit_i,
  input wire logic tx_active_i,
  output logic bit_tick_o,
  output logic rx_bit_o,
  output logic rx_bit_valid_o,
  output logic rx_sync_o
);
  logic [47:0] chips = '0;
  int n_chips = 0;
  logic [2:0] div = '0;
  logic grab = 1'b0;
  initial begin
    bit_tick_o = 1'b0;
    rx_bit_o = 1'b0;
    rx_bit_valid_o = 1'b0;
    rx_sync_o = 1'b0;
  end
  // Free running, so a frame may start anywhere inside a chip period
  always @(negedge sys_clk_i) begin
    div <= div + 3'h1;
    bit_tick_o <= (div == 3'h7);
  end
  // A chip lands one edge after its tick, so it is taken one edge later
  always @(posedge sys_clk_i) begin
    grab <= bit_tick_o & tx_active_i;
    if (grab) begin
      chips <= {chips[46:0], tx_bit_i};
      n_chips <= n_chips + 1;
    end
  end
  task automatic send_byte(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      @(negedge sys_clk_i);
      rx_bit_o = b[i];
      rx_bit_valid_o = 1'b1;
      @(negedge sys_clk_i);
      rx_bit_valid_o = 1'b0;
      // Between chips the line shows the inverted bit, not the chip value
      rx_bit_o = ~b[i];
    end
  endtask : send_byte
  task automatic pulse_sync();
    @(negedge sys_clk_i);
    rx_sync_o = 1'b1;
    @(negedge sys_clk_i);
    rx_sync_o = 1'b0;
  endtask : pulse_sync
endmodule : pfh_modem_model

// File: dv/test_pfh_packet_handler.sv
// Self-checking bench for the packet FIFO handler
`timescale 1ns/1ps
module test_pfh_packet_handler;
  logic sys_clk_i, rst_i, host_wr_i, host_rd_i, bit_tick_i, rx_bit_i, rx_bit_valid_i, rx_sync_i;
  logic tx_bit_o, tx_active_o;
  logic [7:0] host_wdata_i, host_rdata_o;
  pfh_pkg::pfh_cfg_t cfg_i;
  pfh_pkg::pfh_stat_t stat_o;
  int err_total = 0;
  int n_checks = 0;
  pfh_packet_handler uut (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .cfg_i(cfg_i), .host_wr_i(host_wr_i),
    .host_wdata_i(host_wdata_i), .host_rd_i(host_rd_i), .host_rdata_o(host_rdata_o), .bit_tick_i(bit_tick_i),
    .tx_bit_o(tx_bit_o), .tx_active_o(tx_active_o), .rx_bit_i(rx_bit_i), .rx_bit_valid_i(rx_bit_valid_i),
    .rx_sync_i(rx_sync_i), .stat_o(stat_o));
  pfh_modem_model modem (.sys_clk_i(sys_clk_i), .tx_bit_i(tx_bit_o), .tx_active_i(tx_active_o),
    .bit_tick_o(bit_tick_i), .rx_bit_o(rx_bit_i), .rx_bit_valid_o(rx_bit_valid_i), .rx_sync_o(rx_sync_i));
  initial begin
    sys_clk_i = 1'b0;
    forever #12.5 sys_clk_i = ~sys_clk_i;
  end
  task automatic check(input string what, input logic [47:0] seen, input logic [47:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic end_sim();
    $display("Checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : end_sim
  task automatic cycles(input int n);
    repeat (n) @(negedge sys_clk_i);
  endtask : cycles
  task automatic wr_byte(input logic [7:0] b);
    host_wr_i = 1'b1;
    host_wdata_i = b;
    cycles(1);
    host_wr_i = 1'b0;
    cycles(1);
  endtask : wr_byte
  task automatic rd_byte(input logic [7:0] exp);
    check("rdata", host_rdata_o, exp);
    host_rd_i = 1'b1;
    cycles(1);
    host_rd_i = 1'b0;
    cycles(1);
  endtask : rd_byte
  function automatic logic flag(input int k);
    return (k == 0) ? tx_active_o : (k == 1) ? stat_o.tx_done : (modem.n_chips >= 48);
  endfunction : flag
  function automatic logic [15:0] crc16(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] v;
    v = c;
    for (int i = 7; i >= 0; i--) begin
      v = {v[14:0], 1'b0} ^ ((v[15] ^ b[i]) ? pfh_pkg::CRC_POLY : 16'h0000);
    end
    return v;
  endfunction : crc16
  task automatic send_man(input logic [7:0] b);
    logic [15:0] c;
    for (int i = 7; i >= 0; i--) begin
      c[2*i+1 -: 2] = {b[i], ~b[i]};
    end
    modem.send_byte(c[15:8]);
    modem.send_byte(c[7:0]);
  endtask : send_man
  task automatic send_pkt(input logic [7:0] flip);
    logic [15:0] c;
    c = crc16(crc16(crc16(pfh_pkg::CRC_SEED, 8'h02), 8'h5A), 8'h3C);
    modem.pulse_sync();
    send_man(8'h02);
    send_man(8'h5A);
    send_man(8'h3C);
    send_man(c[15:8]);
    send_man(c[7:0] ^ flip);
  endtask : send_pkt
  task automatic wait_flag(input int k, input int lim);
    int i;
    i = 0;
    while (flag(k) !== 1'b1 && i < lim) begin
      cycles(1);
      i++;
    end
    if (i >= lim) begin
      err_total++;
      $display("CHECK FAILED wait %0d expected 1 seen 0", k);
      end_sim();
    end
  endtask : wait_flag
  initial begin
    rst_i = 1'b1;
    host_wr_i = 1'b0;
    host_rd_i = 1'b0;
    host_wdata_i = 8'h00;
    cfg_i = '0;
    cfg_i.chip_mode = pfh_pkg::MODE_STBY;
    cfg_i.data_mode = 2'h2;
    cfg_i.payload_length = 8'h02;
    cfg_i.preamble_size = 2'h1;
    cfg_i.tx_start_cond = 1'b1;
    cfg_i.fifo_stby_access = 1'b1;
    cycles(8);
    rst_i = 1'b0;
    check("reset not_empty", stat_o.fifo_not_empty, 1'b0);
    wr_byte(8'h11);
    check("write in read access", stat_o.fifo_not_empty, 1'b0);
    cfg_i.fifo_stby_access = 1'b0;
    wr_byte(8'h55);
    wr_byte(8'hC3);
    wr_byte(8'h77);
    check("head byte", host_rdata_o, 8'h55);
    $display("test load done");
    modem.n_chips = 0;
    cfg_i.chip_mode = pfh_pkg::MODE_TX;
    cycles(2000);
    check("active before ready", tx_active_o, 1'b0);
    wait_flag(0, 1000);
    wait_flag(1, 600);
    // The last chip is captured one edge after done rises
    cycles(2);
    check("chip count", modem.n_chips, 32);
    check("chips", modem.chips[31:0], 32'hAAAA55C3);
    check("surplus cleared", stat_o.fifo_not_empty, 1'b0);
    // One chip period of grace before leaving transmit
    cycles(8);
    cfg_i.chip_mode = pfh_pkg::MODE_STBY;
    cfg_i.preamble_size = 2'h0;
    cfg_i.tx_start_cond = 1'b0;
    wr_byte(8'h12);
    wr_byte(8'h34);
    wr_byte(8'h56);
    wr_byte(8'h78);
    modem.n_chips = 0;
    cfg_i.chip_mode = pfh_pkg::MODE_TX;
    wait_flag(2, 3500);
    check("queued chips", modem.chips, 48'hAA1234AA5678);
    $display("test transmit done");
    cfg_i.chip_mode = pfh_pkg::MODE_RX;
    cfg_i.adrs_filt = pfh_pkg::FILT_NODE;
    cfg_i.node_adrs = 8'h5A;
    modem.pulse_sync();
    modem.send_byte(8'h5A);
    modem.send_byte(8'h3C);
    check("rx before ready", stat_o.fifo_not_empty, 1'b0);
    cycles(4000);
    modem.pulse_sync();
    modem.send_byte(8'h5A);
    modem.send_byte(8'h3C);
    cycles(2);
    check("payload ready", stat_o.payload_ready, 1'b1);
    check("adrs match", stat_o.adrs_match, 1'b1);
    check("crc ok off", stat_o.crc_ok, 1'b0);
    modem.pulse_sync();
    modem.send_byte(8'h11);
    modem.send_byte(8'h22);
    rd_byte(8'h5A);
    check("ready held", stat_o.payload_ready, 1'b1);
    rd_byte(8'h3C);
    check("ready cleared", stat_o.payload_ready, 1'b0);
    check("match cleared", stat_o.adrs_match, 1'b0);
    check("fifo empty", stat_o.fifo_not_empty, 1'b0);
    modem.pulse_sync();
    modem.send_byte(8'h11);
    modem.send_byte(8'h22);
    cycles(2);
    check("foreign dropped", stat_o.payload_ready, 1'b0);
    check("foreign cleared", stat_o.fifo_not_empty, 1'b0);
    $display("test receive done");
    cfg_i.data_mode = 2'h3;
    cfg_i.pkt_format = 1'b1;
    cfg_i.crc_on = 1'b1;
    cfg_i.manchester_on = 1'b1;
    cfg_i.crc_autoclr = 1'b1;
    send_pkt(8'h00);
    cycles(2);
    check("crc ok", stat_o.crc_ok, 1'b1);
    check("crc status", stat_o.crc_status, 1'b1);
    check("crc ready", stat_o.payload_ready, 1'b1);
    cfg_i.chip_mode = pfh_pkg::MODE_STBY;
    cfg_i.fifo_stby_access = 1'b1;
    rd_byte(8'h5A);
    rd_byte(8'h3C);
    check("stby ready cleared", stat_o.payload_ready, 1'b0);
    check("stby status kept", stat_o.crc_status, 1'b1);
    cfg_i.chip_mode = pfh_pkg::MODE_RX;
    cycles(4010);
    check("status held", stat_o.crc_status, 1'b1);
    send_pkt(8'h01);
    cycles(2);
    check("bad crc cleared", stat_o.fifo_not_empty, 1'b0);
    check("bad crc status", stat_o.crc_status, 1'b0);
    check("bad crc ready", stat_o.payload_ready, 1'b0);
    $display("test crc done");
    cfg_i.chip_mode = pfh_pkg::MODE_STBY;
    cfg_i.fifo_stby_access = 1'b0;
    for (int i = 0; i < 65; i++) begin
      wr_byte(8'(i));
    end
    check("fifo full", stat_o.fifo_full, 1'b1);
    cfg_i.fifo_stby_access = 1'b1;
    for (int i = 0; i < 64; i++) begin
      rd_byte(8'(i));
    end
    check("full drained", stat_o.fifo_not_empty, 1'b0);
    check("full flag off", stat_o.fifo_full, 1'b0);
    $display("test full done");
    end_sim();
  end
endmodule : test_pfh_packet_handler
